/* File: shared/uncore_cfg_pkg.sv */
/*
  Package of constants and carrier types for the non-core generic
  configuration registers: header identity words, requested core setup
  and trace mirror port control.
  Assumes byte addresses inside one function's configuration space.
*/
package uncore_cfg_pkg;

  // ----------------------------------------------------------------
  // Byte offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_FUNCTION_ID = 8'h02;
  localparam logic [7:0] OFS_SILICON_REV = 8'h08;
  localparam logic [7:0] OFS_CORE_CONFIG = 8'h80;
  localparam logic [7:0] OFS_TRACE_CTL = 8'hD0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FUNCTION_ID_LSB = 16;
  localparam int SILICON_REV_LSB = 0;
  localparam int CORE_LOCK_BIT = 16;
  localparam int THREAD_DISABLE_BIT = 8;
  localparam int CORE_COUNT_LSB = 0;
  localparam int TRACE_CTL_LSB = 0;

  // ----------------------------------------------------------------
  // Identity values (arbitrary, neutral)
  // ----------------------------------------------------------------
  localparam logic [15:0] FUNCTION_ID_VALUE = 16'hA5C3;
  localparam logic [7:0] SILICON_REV_VALUE = 8'h5A;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic thread_disable;
    logic [2:0] core_count;
  } core_cfg_t;

  // Packed in register bit order, bit 6 down to bit 0
  typedef struct packed {
    logic enhanced_sync_off;
    logic direct_active_entry;
    logic rx_crc_replace;
    logic rx_port_sel;
    logic tx_port_sel;
    logic rx_enable;
    logic tx_enable;
  } trace_ctl_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] CORE_COUNT_RESET = 3'h0;
  localparam logic THREAD_DISABLE_RESET = 1'b0;
  localparam logic CORE_LOCK_RESET = 1'b0;
  localparam logic [6:0] TRACE_CTL_RESET = 7'h03;

endpackage

/* File: src/pin_filter.sv */
/*
  Three-stage input synchroniser with an agreement filter.
  Assumes an asynchronous pin input and a synchronous active-high reset.
*/
module pin_filter (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PIN,
  output logic LEVEL
);

  logic meta_r;
  logic sync_r;
  logic late_r;
  logic level_r;

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      late_r <= 1'b0;
    end else begin
      meta_r <= PIN;
      sync_r <= meta_r;
      late_r <= sync_r;
    end
  end

  // Change accepted only once stages two and three agree
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      level_r <= 1'b0;
    end else if (sync_r == late_r) begin
      level_r <= late_r;
    end
  end

  assign LEVEL = level_r;

endmodule // pin_filter

/* File: src/uncore_generic_config_regs.sv */
/*
  Generic non-core configuration registers: header identity words,
  requested core and thread setup with lock, trace mirror port control.
  Assumes a simple single-cycle configuration access port and a
  processor reset pin that is asynchronous to SYS_CLK.
*/
module uncore_generic_config_regs (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [7:0] CFG_ADDR,
  input wire logic CFG_WR,
  input wire logic CFG_RD,
  input wire logic [3:0] CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  output logic [31:0] CFG_RDATA,
  output logic CFG_RVALID,
  input wire logic PROC_RST_PIN,
  output uncore_cfg_pkg::core_cfg_t ACTIVE_CFG,
  output uncore_cfg_pkg::trace_ctl_t TRACE_CTL
);

  uncore_cfg_pkg::core_cfg_t req_cfg_r;
  uncore_cfg_pkg::core_cfg_t active_cfg_r;
  uncore_cfg_pkg::trace_ctl_t trace_ctl_r;
  logic core_lock_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic proc_rst_lvl;
  logic proc_rst_prev_r;
  logic proc_rst_release;
  logic [5:0] dword;
  logic hit_id;
  logic hit_rev;
  logic hit_core;
  logic hit_trace;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign dword = CFG_ADDR[7:2];
  assign hit_id = dword == uncore_cfg_pkg::OFS_FUNCTION_ID[7:2];
  assign hit_rev = dword == uncore_cfg_pkg::OFS_SILICON_REV[7:2];
  assign hit_core = dword == uncore_cfg_pkg::OFS_CORE_CONFIG[7:2];
  assign hit_trace = dword == uncore_cfg_pkg::OFS_TRACE_CTL[7:2];

  // ----------------------------------------------------------------
  // Processor reset pin
  // ----------------------------------------------------------------
  pin_filter u_proc_rst (
    .SYS_CLK(SYS_CLK),
    .RST(RST),
    .PIN(PROC_RST_PIN),
    .LEVEL(proc_rst_lvl)
  );

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      proc_rst_prev_r <= 1'b0;
    end else begin
      proc_rst_prev_r <= proc_rst_lvl;
    end
  end

  // New setup is taken when the processor leaves reset
  assign proc_rst_release = proc_rst_prev_r & ~proc_rst_lvl;

  // ----------------------------------------------------------------
  // Requested core configuration
  // ----------------------------------------------------------------
  // Lock only falls on RST, so a processor reset alone cannot reopen it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      core_lock_r <= uncore_cfg_pkg::CORE_LOCK_RESET;
    end else if (CFG_WR && hit_core && CFG_BE[2] && CFG_WDATA[uncore_cfg_pkg::CORE_LOCK_BIT]) begin
      core_lock_r <= 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      req_cfg_r.thread_disable <= uncore_cfg_pkg::THREAD_DISABLE_RESET;
      req_cfg_r.core_count <= uncore_cfg_pkg::CORE_COUNT_RESET;
    end else if (CFG_WR && hit_core && !core_lock_r) begin
      if (CFG_BE[1]) begin
        req_cfg_r.thread_disable <= CFG_WDATA[uncore_cfg_pkg::THREAD_DISABLE_BIT];
      end
      if (CFG_BE[0]) begin
        req_cfg_r.core_count <= CFG_WDATA[uncore_cfg_pkg::CORE_COUNT_LSB +: 3];
      end
    end
  end

  // Count only; choosing which cores to idle is left downstream
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      active_cfg_r.thread_disable <= uncore_cfg_pkg::THREAD_DISABLE_RESET;
      active_cfg_r.core_count <= uncore_cfg_pkg::CORE_COUNT_RESET;
    end else if (proc_rst_release) begin
      active_cfg_r <= req_cfg_r;
    end
  end

  assign ACTIVE_CFG = active_cfg_r;

  // ----------------------------------------------------------------
  // Trace mirror port control
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      trace_ctl_r <= uncore_cfg_pkg::TRACE_CTL_RESET;
    end else if (CFG_WR && hit_trace && CFG_BE[0]) begin
      trace_ctl_r <= CFG_WDATA[uncore_cfg_pkg::TRACE_CTL_LSB +: 7];
    end
  end

  assign TRACE_CTL = trace_ctl_r;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit_id) begin
      rdata_nxt[uncore_cfg_pkg::FUNCTION_ID_LSB +: 16] = uncore_cfg_pkg::FUNCTION_ID_VALUE;
    end else if (hit_rev) begin
      rdata_nxt[uncore_cfg_pkg::SILICON_REV_LSB +: 8] = uncore_cfg_pkg::SILICON_REV_VALUE;
    end else if (hit_core) begin
      rdata_nxt[uncore_cfg_pkg::CORE_LOCK_BIT] = core_lock_r;
      rdata_nxt[uncore_cfg_pkg::THREAD_DISABLE_BIT] = req_cfg_r.thread_disable;
      rdata_nxt[uncore_cfg_pkg::CORE_COUNT_LSB +: 3] = req_cfg_r.core_count;
    end else if (hit_trace) begin
      rdata_nxt[uncore_cfg_pkg::TRACE_CTL_LSB +: 7] = trace_ctl_r;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      rdata_r <= 32'h0000_0000;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= CFG_RD;
      if (CFG_RD) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign CFG_RDATA = rdata_r;
  assign CFG_RVALID = rvalid_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  sequence seq_core_write;
    CFG_WR && hit_core && !core_lock_r;
  endsequence

  sequence seq_trace_write;
    CFG_WR && hit_trace && CFG_BE[0];
  endsequence

  // Expected words built from the package so a changed identity cannot drift
  a_id_read_value: assert property (CFG_RD && hit_id |=> CFG_RVALID &&
    CFG_RDATA == {uncore_cfg_pkg::FUNCTION_ID_VALUE, 16'h0000})
    else $error("function identifier read wrong");
  a_rev_read_value: assert property (CFG_RD && hit_rev |=> CFG_RVALID &&
    CFG_RDATA == {24'h00_0000, uncore_cfg_pkg::SILICON_REV_VALUE})
    else $error("silicon revision read wrong");
  a_lock_stays_set: assert property (core_lock_r |=> core_lock_r)
    else $error("lock bit cleared");
  a_lock_blocks_write: assert property (core_lock_r |=> $stable(req_cfg_r))
    else $error("locked fields changed");
  a_active_held: assert property (!proc_rst_release |=> $stable(active_cfg_r))
    else $error("active setup changed without reset");
  a_active_applied: assert property (proc_rst_release |=> active_cfg_r == $past(req_cfg_r))
    else $error("requested setup not applied");
  a_count_written: assert property (seq_core_write ##0 CFG_BE[0] |=> req_cfg_r.core_count == $past(CFG_WDATA[2:0]))
    else $error("core count not stored");
  a_trace_written: assert property (seq_trace_write |=> trace_ctl_r == $past(CFG_WDATA[6:0]))
    else $error("trace control not stored");
  a_trace_reset_val: assert property ($past(RST) |-> trace_ctl_r == uncore_cfg_pkg::TRACE_CTL_RESET &&
    req_cfg_r.core_count == uncore_cfg_pkg::CORE_COUNT_RESET)
    else $error("reset values wrong");
  a_reserved_zero: assert property (CFG_RD && hit_trace ##1 CFG_RVALID |-> CFG_RDATA[31:7] == 25'h0)
    else $error("reserved bits not zero");

endmodule // uncore_generic_config_regs

/* File: tb/test_uncore_generic_config_regs.sv */
/*
  Self-checking bench for the generic config registers.
  Assumes read data one cycle after the read strobe.
*/
module test_uncore_generic_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic rvalid;
  logic pin = 1'b0;
  uncore_cfg_pkg::core_cfg_t act;
  uncore_cfg_pkg::trace_ctl_t tctl;
  logic [31:0] exp_q[$];
  logic [31:0] d;
  logic [6:0] tv;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;

  uncore_generic_config_regs u_dut (
    .SYS_CLK(sys_clk), .RST(rst), .CFG_ADDR(addr), .CFG_WR(wr),
    .CFG_RD(rd), .CFG_BE(be), .CFG_WDATA(wdata), .CFG_RDATA(rdata),
    .CFG_RVALID(rvalid), .PROC_RST_PIN(pin), .ACTIVE_CFG(act),
    .TRACE_CTL(tctl)
  );

  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Compare, report and access tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One strobe cycle; a gap cycle follows so strobes never merge
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
    @(posedge sys_clk);
    #1;
    wr = w;
    rd = !w;
    addr = a;
    be = b;
    wdata = v;
    @(posedge sys_clk);
    #1;
    wr = 1'b0;
    rd = 1'b0;
  endtask

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(1'b0, a, 4'h0, 32'h0);
  endtask

  // Negedge sampling keeps clear of the edge that launches read data
  always @(negedge sys_clk) begin
    if (rvalid === 1'b1) begin
      // An unasked-for read pulse is a mismatch even when its data is unknown
      if (exp_q.size() > 0) begin
        check(rdata, exp_q.pop_front());
      end else begin
        check({31'h0000_0000, rvalid}, 32'h0000_0000);
      end
    end
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'hFE4BC169));
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    check({25'h0, tctl}, 32'h3);
    check({28'h0, act}, 32'h0);
    rd_exp(8'h80, 32'h0);
    rd_exp(8'hD0, 32'h3);
    acc(1'b1, 8'h00, 4'hF, 32'hFFFFFFFF);
    acc(1'b1, 8'h08, 4'hF, 32'hFFFFFFFF);
    acc(1'b1, 8'h40, 4'hF, $urandom);
    rd_exp(8'h00, {uncore_cfg_pkg::FUNCTION_ID_VALUE, 16'h0});
    rd_exp(8'h08, {24'h0, uncore_cfg_pkg::SILICON_REV_VALUE});
    rd_exp(8'h40, 32'h0);
    $display("test identity done");
    for (int i = 0; i < 8; i++) begin
      tv = (i < 7) ? 7'h01 << i : 7'($urandom);
      acc(1'b1, 8'hD0, 4'h1, {25'($urandom), tv});
      check({25'h0, tctl}, {25'h0, tv});
      rd_exp(8'hD0, {25'h0, tv});
    end
    acc(1'b1, 8'hD0, 4'hE, ~{25'h0, tv});
    check({25'h0, tctl}, {25'h0, tv});
    $display("test trace control done");
    for (int i = 0; i < 6; i++) begin
      d = $urandom;
      d[2:0] = 3'(i);
      // Lane 2 is off, so a random lock bit must not land
      acc(1'b1, 8'h80, 4'h3, d);
      rd_exp(8'h80, d & 32'h00000107);
      check({28'h0, act}, 32'h0);
    end
    acc(1'b1, 8'h80, 4'hF, 32'hFFFFFF05);
    rd_exp(8'h80, 32'h00010105);
    acc(1'b1, 8'h80, 4'hF, 32'h0);
    rd_exp(8'h80, 32'h00010105);
    pin = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    pin = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    check({28'h0, act}, 32'h0);
    repeat (5) @(posedge sys_clk);
    #1;
    check({28'h0, act}, 32'hD);
    check(32'(exp_q.size()), 32'h0);
    $display("test core config done");
    report_and_stop();
  end
endmodule // test_uncore_generic_config_regs
